/* File: pwmc_map.vh */
`ifndef PWMC_MAP_VH
`define PWMC_MAP_VH

// Register byte offsets
`define PWMC_PRE_OFF 8'h00
`define PWMC_CLKDIV_OFF 8'h04
`define PWMC_CTRL_OFF 8'h08
`define PWMC_PER0_OFF 8'h0C
`define PWMC_DUTY0_OFF 8'h10
`define PWMC_CNT0_OFF 8'h14
`define PWMC_CH_STRIDE 8'h0C
`define PWMC_IEN_OFF 8'h24
`define PWMC_IFLAG_OFF 8'h28
`define PWMC_CAPC_OFF 8'h2C
`define PWMC_RISE0_OFF 8'h30
`define PWMC_FALL0_OFF 8'h34
`define PWMC_CAP_STRIDE 8'h08
`define PWMC_SYNC_OFF 8'h40
`define PWMC_PIN_OFF 8'h44
`define PWMC_LAST_OFF 8'h44

// Prescaler register fields
`define PWMC_PRE_LSB 0
`define PWMC_DZI_LSB 8
// Clock divider select: code n divides by 2**n for codes 0 to 4; codes 5 to 7 divide by 16
`define PWMC_DIV_STRIDE 4
// Control register fields
`define PWMC_EN_BIT 0
`define PWMC_MODE_BIT 3
`define PWMC_DZEN_BIT 4
`define PWMC_CTRL_STRIDE 8
`define PWMC_CENTER_BIT 31
// Interrupt enable register fields
`define PWMC_PIE_BIT 0
`define PWMC_ADCT_BIT 8
`define PWMC_ITYPE_LSB 16
`define PWMC_ITYPE_UNDER 2'h0
`define PWMC_ITYPE_CENTER 2'h1
// Capture control fields
`define PWMC_CAPEN_BIT 0
`define PWMC_RIE_BIT 1
`define PWMC_FIE_BIT 2
`define PWMC_CFLAG_BIT 4
`define PWMC_CAPC_STRIDE 16
// Pin control fields
`define PWMC_POE_BIT 0
`define PWMC_CAPIN_BIT 8

`endif

/* File: pwmc_chan.v */
`timescale 1ns/1ps
module pwmc_chan #(
    parameter CW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire tick_pre,
    input wire [2:0] div_sel,
    input wire run_en,
    input wire auto_reload_select,
    input wire center,
    input wire [CW-1:0] per_buf,
    input wire [CW-1:0] duty_buf,
    input wire cap_in,
    input wire cap_en,
    input wire rise_ie,
    input wire fall_ie,
    output wire [CW-1:0] cnt,
    output wire pwm,
    output wire uf_evt,
    output wire ctr_evt,
    output wire os_done,
    output wire rise_evt,
    output wire fall_evt
);
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] per_q;
    reg [CW-1:0] duty_q;
    reg [3:0] div_q;
    reg up_q;
    reg idle_q;
    reg pwm_q;
    reg cap_prev_q;
    wire [4:0] m5 = (5'h01 << div_sel) - 5'h01;
    wire [3:0] mask = m5[3:0];
    wire tick = tick_pre & ((div_q & mask) == mask);
    wire live = run_en & ~idle_q;
    wire at_zero = (cnt_q == {CW{1'b0}});
    wire at_top = (cnt_q == per_q);
    wire cap_rl = (rise_evt & rise_ie) | (fall_evt & fall_ie);
    wire reload_ok = auto_reload_select & (per_buf != {CW{1'b0}});
    wire [CW-1:0] start_cnt = center ? {CW{1'b0}} : per_buf;

    assign rise_evt = cap_en & cap_in & ~cap_prev_q;
    assign fall_evt = cap_en & ~cap_in & cap_prev_q;
    assign uf_evt = tick & live & at_zero & (~center | ~up_q);
    assign ctr_evt = tick & live & center & up_q & at_top;
    assign os_done = uf_evt & ~auto_reload_select;
    assign cnt = cnt_q;
    assign pwm = pwm_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 4'h0;
            cap_prev_q <= 1'b0;
        end else begin
            cap_prev_q <= cap_in;
            if (tick_pre) begin
                div_q <= div_q + 4'h1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= {CW{1'b0}};
            per_q <= {CW{1'b0}};
            duty_q <= {CW{1'b0}};
            up_q <= 1'b1;
            idle_q <= 1'b1;
            pwm_q <= 1'b0;
        end else begin
            // Output falls at once on disable, cutting the pulse short
            pwm_q <= live & ((up_q | ~center) ? (cnt_q <= duty_q) :
                (cnt_q < duty_q));
            if (!run_en) begin
                idle_q <= 1'b1;
                cnt_q <= {CW{1'b0}};
                up_q <= 1'b1;
            end else if (idle_q) begin
                if (per_buf != {CW{1'b0}}) begin
                    per_q <= per_buf;
                    duty_q <= duty_buf;
                    cnt_q <= start_cnt;
                    up_q <= 1'b1;
                    idle_q <= 1'b0;
                end
            end else if (cap_rl) begin
                cnt_q <= per_q;
            end else if (tick) begin
                if (uf_evt) begin
                    if (reload_ok) begin
                        per_q <= per_buf;
                        duty_q <= duty_buf;
                        cnt_q <= start_cnt;
                        up_q <= 1'b1;
                    end else begin
                        idle_q <= 1'b1;
                    end
                end else if (center && up_q) begin
                    if (at_top) begin
                        up_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                    end
                end else begin
                    cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: pwmc_top.v */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pwmc_map.vh"
module pwmc_top #(
    parameter CW = 16,
    parameter GROUP_B = 0
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [1:0] cap_pin_in,
    output wire [1:0] pwm_pin_out,
    output wire [1:0] pwm_pin_oe_n,
    output wire [1:0] adc_start,
    output wire group_a_irq,
    output wire group_b_irq
);
    localparam NCH = 2;

    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a <= `PWMC_LAST_OFF);
        end
    endfunction

    function [7:0] ch_addr;
        input [7:0] base;
        input [7:0] stride;
        input integer idx;
        reg [15:0] t;
        begin
            t = idx[7:0] * stride;
            ch_addr = base + t[7:0];
        end
    endfunction

    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    reg pready_d;
    reg pslverr_d;
    reg [31:0] prdata_d;
    reg [7:0] pre_q;
    reg [7:0] deadzone_interval_q;
    reg [7:0] pre_cnt_q;
    reg dzen_q;
    reg center_q;
    reg [1:0] center_irq_point_select_q;
    reg sync_q;
    reg [NCH-1:0] channel_run_enable_q;
    reg [NCH-1:0] auto_reload_select_q;
    reg [NCH-1:0] pie_q;
    reg [NCH-1:0] adc_trigger_enable_q;
    reg [NCH-1:0] pflag_q;
    reg [NCH-1:0] cap_en_q;
    reg [NCH-1:0] rie_q;
    reg [NCH-1:0] fie_q;
    reg [NCH-1:0] capture_irq_flag_q;
    reg [NCH-1:0] pin_output_enable_q;
    reg [NCH-1:0] capture_input_enable_q;
    reg [NCH-1:0] adc_q;
    reg [NCH-1:0] pin_out_q;
    reg [NCH-1:0] pin_oe_n_q;
    reg irq_a_q;
    reg irq_b_q;
    reg [2:0] div_sel_q [0:NCH-1];
    reg [CW-1:0] period_reload_value_q [0:NCH-1];
    reg [CW-1:0] duty_compare_value_q [0:NCH-1];
    reg [CW-1:0] rising_edge_latch_q [0:NCH-1];
    reg [CW-1:0] falling_edge_latch_q [0:NCH-1];
    reg [31:0] ctrl_w;
    reg [31:0] ien_w;
    reg [31:0] capc_w;
    reg [31:0] pin_w;
    reg [31:0] clkdiv_w;
    reg [NCH-1:0] pset;
    reg [NCH-1:0] cset;
    reg any_irq;

    wire [CW*NCH-1:0] cnt_w;
    wire [NCH-1:0] pwm_w;
    wire [NCH-1:0] uf_w;
    wire [NCH-1:0] ctr_w;
    wire [NCH-1:0] done_w;
    wire [NCH-1:0] rise_w;
    wire [NCH-1:0] fall_w;
    wire [NCH-1:0] dz_src;
    wire [NCH-1:0] dz_out;

    // Write lands on the edge where the master sees pready high
    wire acc = psel & penable;
    wire wr_fire = acc & pwrite & pready_q & addr_ok(paddr);
    wire wr_pre = wr_fire & (paddr == `PWMC_PRE_OFF);
    wire wr_div = wr_fire & (paddr == `PWMC_CLKDIV_OFF);
    wire wr_ctrl = wr_fire & (paddr == `PWMC_CTRL_OFF);
    wire wr_ien = wr_fire & (paddr == `PWMC_IEN_OFF);
    wire wr_iflag = wr_fire & (paddr == `PWMC_IFLAG_OFF);
    wire wr_capc = wr_fire & (paddr == `PWMC_CAPC_OFF);
    wire wr_pin = wr_fire & (paddr == `PWMC_PIN_OFF);
    wire tick_pre = (pre_cnt_q >= pre_q);
    wire [NCH-1:0] cap_in = cap_pin_in & capture_input_enable_q;
    wire [NCH-1:0] wr_per;
    wire [NCH-1:0] wr_duty;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            assign wr_per[g] = wr_fire & (paddr ==
                ch_addr(`PWMC_PER0_OFF, `PWMC_CH_STRIDE, g));
            assign wr_duty[g] = wr_fire & (paddr ==
                ch_addr(`PWMC_DUTY0_OFF, `PWMC_CH_STRIDE, g));
            pwmc_chan #(
                .CW(CW)
            ) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .tick_pre(tick_pre),
                .div_sel(div_sel_q[g]),
                .run_en(channel_run_enable_q[g]),
                .auto_reload_select(auto_reload_select_q[g]),
                .center(center_q),
                .per_buf(period_reload_value_q[g]),
                .duty_buf(duty_compare_value_q[g]),
                .cap_in(cap_in[g]),
                .cap_en(cap_en_q[g]),
                .rise_ie(rie_q[g]),
                .fall_ie(fie_q[g]),
                .cnt(cnt_w[g*CW +: CW]),
                .pwm(pwm_w[g]),
                .uf_evt(uf_w[g]),
                .ctr_evt(ctr_w[g]),
                .os_done(done_w[g]),
                .rise_evt(rise_w[g]),
                .fall_evt(fall_w[g])
            );
        end
    endgenerate

    // Pair follows channel 0; lane 1 is its complement while enabled
    assign dz_src[0] = pwm_w[0];
    assign dz_src[1] = dzen_q ? (~pwm_w[0] & channel_run_enable_q[0]) :
        pwm_w[1];

    generate
        for (g = 0; g < NCH; g = g + 1) begin : gdz
            reg [7:0] dz_cnt_q;
            reg dz_q;
            assign dz_out[g] = dzen_q ? dz_q : dz_src[g];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dz_cnt_q <= 8'h00;
                    dz_q <= 1'b0;
                end else if (!dz_src[g]) begin
                    dz_cnt_q <= 8'h00;
                    dz_q <= 1'b0;
                end else if (dz_cnt_q == deadzone_interval_q) begin
                    dz_q <= 1'b1;
                end else if (tick_pre) begin
                    dz_cnt_q <= dz_cnt_q + 8'h01;
                end
            end
        end
    endgenerate

    integer i, j, k;

    always @* begin
        ctrl_w = 32'h0000_0000;
        ien_w = 32'h0000_0000;
        capc_w = 32'h0000_0000;
        pin_w = 32'h0000_0000;
        clkdiv_w = 32'h0000_0000;
        pset = {NCH{1'b0}};
        cset = {NCH{1'b0}};
        ctrl_w[`PWMC_DZEN_BIT] = dzen_q;
        ctrl_w[`PWMC_CENTER_BIT] = center_q;
        ien_w[`PWMC_ITYPE_LSB +: 2] = center_irq_point_select_q;
        for (j = 0; j < NCH; j = j + 1) begin
            ctrl_w[`PWMC_EN_BIT + j*`PWMC_CTRL_STRIDE] =
                channel_run_enable_q[j];
            ctrl_w[`PWMC_MODE_BIT + j*`PWMC_CTRL_STRIDE] =
                auto_reload_select_q[j];
            ien_w[`PWMC_PIE_BIT + j] = pie_q[j];
            ien_w[`PWMC_ADCT_BIT + j] = adc_trigger_enable_q[j];
            capc_w[`PWMC_CAPEN_BIT + j*`PWMC_CAPC_STRIDE] = cap_en_q[j];
            capc_w[`PWMC_RIE_BIT + j*`PWMC_CAPC_STRIDE] = rie_q[j];
            capc_w[`PWMC_FIE_BIT + j*`PWMC_CAPC_STRIDE] = fie_q[j];
            capc_w[`PWMC_CFLAG_BIT + j*`PWMC_CAPC_STRIDE] =
                capture_irq_flag_q[j];
            pin_w[`PWMC_POE_BIT + j] = pin_output_enable_q[j];
            pin_w[`PWMC_CAPIN_BIT + j] = capture_input_enable_q[j];
            clkdiv_w[j*`PWMC_DIV_STRIDE +: 3] = div_sel_q[j];
            if (center_q) begin
                if (center_irq_point_select_q == `PWMC_ITYPE_UNDER) begin
                    pset[j] = uf_w[j];
                end else if (center_irq_point_select_q ==
                    `PWMC_ITYPE_CENTER) begin
                    pset[j] = ctr_w[j];
                end
            end else begin
                pset[j] = uf_w[j];
            end
            cset[j] = (rise_w[j] & rie_q[j]) |
                (fall_w[j] & fie_q[j]);
        end
        any_irq = |((pflag_q & pie_q) | capture_irq_flag_q);
    end

    always @* begin
        pready_d = acc & ~pready_q;
        pslverr_d = acc & ~pready_q & ~addr_ok(paddr);
        prdata_d = 32'h0000_0000;
        case (paddr)
            `PWMC_PRE_OFF: begin
                prdata_d[`PWMC_PRE_LSB +: 8] = pre_q;
                prdata_d[`PWMC_DZI_LSB +: 8] = deadzone_interval_q;
            end
            `PWMC_CLKDIV_OFF: prdata_d = clkdiv_w;
            `PWMC_CTRL_OFF: prdata_d = ctrl_w;
            `PWMC_IEN_OFF: prdata_d = ien_w;
            `PWMC_IFLAG_OFF: prdata_d[NCH-1:0] = pflag_q;
            `PWMC_CAPC_OFF: prdata_d = capc_w;
            `PWMC_SYNC_OFF: prdata_d[0] = sync_q;
            `PWMC_PIN_OFF: prdata_d = pin_w;
            default: prdata_d = 32'h0000_0000;
        endcase
        for (k = 0; k < NCH; k = k + 1) begin
            if (paddr == ch_addr(`PWMC_PER0_OFF, `PWMC_CH_STRIDE, k)) begin
                prdata_d[CW-1:0] = period_reload_value_q[k];
            end
            if (paddr == ch_addr(`PWMC_DUTY0_OFF, `PWMC_CH_STRIDE, k)) begin
                prdata_d[CW-1:0] = duty_compare_value_q[k];
            end
            if (paddr == ch_addr(`PWMC_CNT0_OFF, `PWMC_CH_STRIDE, k)) begin
                prdata_d[CW-1:0] = cnt_w[k*CW +: CW];
            end
            if (paddr == ch_addr(`PWMC_RISE0_OFF, `PWMC_CAP_STRIDE, k)) begin
                prdata_d[CW-1:0] = rising_edge_latch_q[k];
            end
            if (paddr == ch_addr(`PWMC_FALL0_OFF, `PWMC_CAP_STRIDE, k)) begin
                prdata_d[CW-1:0] = falling_edge_latch_q[k];
            end
        end
        if (!pready_d) begin
            prdata_d = prdata_q;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pre_q <= 8'h00;
            pre_cnt_q <= 8'h00;
            deadzone_interval_q <= 8'h00;
            dzen_q <= 1'b0;
            center_q <= 1'b0;
            center_irq_point_select_q <= `PWMC_ITYPE_UNDER;
            sync_q <= 1'b0;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
            adc_q <= {NCH{1'b0}};
            pin_out_q <= {NCH{1'b0}};
            pin_oe_n_q <= {NCH{1'b1}};
            channel_run_enable_q <= {NCH{1'b0}};
            auto_reload_select_q <= {NCH{1'b0}};
            pie_q <= {NCH{1'b0}};
            adc_trigger_enable_q <= {NCH{1'b0}};
            pflag_q <= {NCH{1'b0}};
            cap_en_q <= {NCH{1'b0}};
            rie_q <= {NCH{1'b0}};
            fie_q <= {NCH{1'b0}};
            capture_irq_flag_q <= {NCH{1'b0}};
            pin_output_enable_q <= {NCH{1'b0}};
            capture_input_enable_q <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                div_sel_q[i] <= 3'h0;
                period_reload_value_q[i] <= {CW{1'b0}};
                duty_compare_value_q[i] <= {CW{1'b0}};
                rising_edge_latch_q[i] <= {CW{1'b0}};
                falling_edge_latch_q[i] <= {CW{1'b0}};
            end
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            pre_cnt_q <= tick_pre ? 8'h00 : pre_cnt_q + 8'h01;
            // PWM clock is the bus clock here, so a write crosses in one cycle
            sync_q <= wr_pre | wr_div | wr_ctrl | (|wr_per) |
                (|wr_duty);
            irq_a_q <= any_irq & (GROUP_B == 0);
            irq_b_q <= any_irq & (GROUP_B != 0);
            adc_q <= adc_trigger_enable_q & ctr_w;
            pin_out_q <= pin_output_enable_q & dz_out;
            pin_oe_n_q <= ~pin_output_enable_q;
            if (wr_pre) begin
                pre_q <= pwdata[`PWMC_PRE_LSB +: 8];
                deadzone_interval_q <= pwdata[`PWMC_DZI_LSB +: 8];
            end
            if (wr_ctrl) begin
                dzen_q <= pwdata[`PWMC_DZEN_BIT];
                center_q <= pwdata[`PWMC_CENTER_BIT];
            end
            if (wr_ien) begin
                center_irq_point_select_q <= pwdata[`PWMC_ITYPE_LSB +: 2];
            end
            for (i = 0; i < NCH; i = i + 1) begin
                if (wr_div) begin
                    div_sel_q[i] <= pwdata[i*`PWMC_DIV_STRIDE +: 3];
                end
                if (wr_ctrl) begin
                    channel_run_enable_q[i] <=
                        pwdata[`PWMC_EN_BIT + i*`PWMC_CTRL_STRIDE];
                    auto_reload_select_q[i] <=
                        pwdata[`PWMC_MODE_BIT + i*`PWMC_CTRL_STRIDE];
                end
                if (wr_ien) begin
                    pie_q[i] <= pwdata[`PWMC_PIE_BIT + i];
                    adc_trigger_enable_q[i] <= pwdata[`PWMC_ADCT_BIT + i];
                end
                if (wr_capc) begin
                    cap_en_q[i] <= pwdata[`PWMC_CAPEN_BIT + i*`PWMC_CAPC_STRIDE];
                    rie_q[i] <= pwdata[`PWMC_RIE_BIT + i*`PWMC_CAPC_STRIDE];
                    fie_q[i] <= pwdata[`PWMC_FIE_BIT + i*`PWMC_CAPC_STRIDE];
                end
                if (wr_pin) begin
                    pin_output_enable_q[i] <= pwdata[`PWMC_POE_BIT + i];
                    capture_input_enable_q[i] <= pwdata[`PWMC_CAPIN_BIT + i];
                end
                // A fresh write wins over the hardware clear
                if (wr_per[i]) begin
                    period_reload_value_q[i] <= pwdata[CW-1:0];
                end else if (done_w[i] || (wr_ctrl &&
                    pwdata[`PWMC_MODE_BIT + i*`PWMC_CTRL_STRIDE] !=
                    auto_reload_select_q[i])) begin
                    period_reload_value_q[i] <= {CW{1'b0}};
                end
                if (wr_duty[i]) begin
                    duty_compare_value_q[i] <= pwdata[CW-1:0];
                end else if (done_w[i] || (wr_ctrl &&
                    pwdata[`PWMC_MODE_BIT + i*`PWMC_CTRL_STRIDE] !=
                    auto_reload_select_q[i])) begin
                    duty_compare_value_q[i] <= {CW{1'b0}};
                end
                // Hardware set beats a same-cycle write-one clear
                if (pset[i]) begin
                    pflag_q[i] <= 1'b1;
                end else if (wr_iflag && pwdata[i]) begin
                    pflag_q[i] <= 1'b0;
                end
                if (cset[i]) begin
                    capture_irq_flag_q[i] <= 1'b1;
                end else if (wr_capc &&
                    pwdata[`PWMC_CFLAG_BIT + i*`PWMC_CAPC_STRIDE]) begin
                    capture_irq_flag_q[i] <= 1'b0;
                end
                if (rise_w[i]) begin
                    rising_edge_latch_q[i] <= cnt_w[i*CW +: CW];
                end
                if (fall_w[i]) begin
                    falling_edge_latch_q[i] <= cnt_w[i*CW +: CW];
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pwm_pin_out = pin_out_q;
    assign pwm_pin_oe_n = pin_oe_n_q;
    assign adc_start = adc_q;
    assign group_a_irq = irq_a_q;
    assign group_b_irq = irq_b_q;
endmodule

/* File: pwmc_top_sva.sv */
`timescale 1ns/1ps
module pwmc_chk #(
    parameter GROUP_B = 0
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] pwm_pin_out,
    input wire [1:0] pwm_pin_oe_n,
    input wire [1:0] adc_start,
    input wire group_b_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad_adr = (paddr > 8'h44) || (paddr[1:0] != 2'h0);
    wire stop_wr = psel && penable && pready && pwrite && paddr == 8'h08;
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_pulse;
        pready ##1 !pready;
    endsequence
    a_ready_wait: assert property (s_wait |=> s_pulse)
        else $error("ready not one cycle after access");
    a_ready_only: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_decode: assert property (pready |-> pslverr == bad_adr)
        else $error("error flag against address");
    a_err_rdata: assert property (pready && pslverr && !pwrite |->
        prdata == 32'h0) else $error("refused read not zero");
    a_pin_quiet: assert property ((pwm_pin_out & pwm_pin_oe_n) == 2'h0)
        else $error("pin level without enable");
    a_adc_pulse: assert property (adc_start[0] |=> !adc_start[0])
        else $error("adc start longer than one cycle");
    a_irqb_idle: assert property (GROUP_B == 0 |-> !group_b_irq)
        else $error("unused group line raised");
    a_stop_out: assert property (stop_wr && !pwdata[0] |->
        ##[1:4] !pwm_pin_out[0]) else $error("output kept after disable");
endmodule

bind pwmc_top pwmc_chk #(.GROUP_B(GROUP_B)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pwm_pin_out, .pwm_pin_oe_n, .adc_start, .group_b_irq);

/* File: pwmc_stage.sv */
`timescale 1ns/1ps
module pwmc_stage (
    input wire pclk,
    input wire [1:0] pwm_pin_out,
    input wire [1:0] pwm_pin_oe_n,
    input wire [1:0] cap_lvl,
    output reg [1:0] cap_pin_in,
    output wire [1:0] gate_lvl
);
    // Undriven pin falls to the gate's pull-down
    assign gate_lvl = pwm_pin_out & ~pwm_pin_oe_n;
    initial cap_pin_in = 2'h0;
    // Source is presented already synchronised to pclk
    always @(posedge pclk) cap_pin_in <= cap_lvl;
endmodule

/* File: pwm_timer_with_capture_tb_top.sv */
`timescale 1ns/1ps
module pwm_timer_with_capture_tb_top;
    reg pclk = 1'h0;
    reg presetn = 1'h0;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [1:0] cap_lvl = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, group_a_irq, group_b_irq;
    wire [1:0] cap_pin_in, pwm_pin_out, pwm_pin_oe_n, adc_start, gate_lvl;
    reg [31:0] rv;
    reg ev;
    integer bad_count = 0;
    integer checks = 0;
    integer hi = 0;
    integer adc = 0;
    integer h0, a0, dh, da;
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        hi <= hi + gate_lvl[0];
        adc <= adc + adc_start[0];
    end
    pwmc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cap_pin_in, .pwm_pin_out, .pwm_pin_oe_n,
        .adc_start, .group_a_irq, .group_b_irq);
    pwmc_stage stage (.pclk, .pwm_pin_out, .pwm_pin_oe_n, .cap_lvl,
        .cap_pin_in, .gate_lvl);
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks = checks + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rv, e);
    endtask
    // Window spans whole periods, so the phase does not matter
    task win;
        h0 = hi;
        a0 = adc;
        repeat (64) @(posedge pclk);
        dh = hi - h0;
        da = adc - a0;
    endtask
    task t_regs;
        rc(8'h08, 32'h0);
        apb(1'h0, 8'h46, 32'h0);
        chk(ev, 1'h1);
        wr(8'h14, 32'h5);
        rc(8'h14, 32'h0);
        $display("regs done");
    endtask
    task t_oneshot;
        wr(8'h44, 32'h1);
        wr(8'h08, 32'h1);
        wr(8'h10, 32'h0);
        wr(8'h0C, 32'h2);
        rc(8'h40, 32'h0);
        repeat (10) @(posedge pclk);
        rc(8'h0C, 32'h0);
        rc(8'h10, 32'h0);
        rc(8'h28, 32'h1);
        $display("oneshot done");
    endtask
    task t_reload;
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h1);
        wr(8'h0C, 32'h5);
        wr(8'h08, 32'h9);
        rc(8'h0C, 32'h0);
        repeat (30) @(posedge pclk);
        rc(8'h14, 32'h0);
        wr(8'h10, 32'h1);
        wr(8'h0C, 32'h3);
        repeat (20) @(posedge pclk);
        win;
        chk(dh, 32'h20);
        wr(8'h10, 32'h2);
        repeat (40) @(posedge pclk);
        win;
        chk(dh, 32'h30);
        wr(8'h08, 32'h8);
        repeat (4) @(posedge pclk);
        chk(gate_lvl[0], 1'h0);
        $display("reload done");
    endtask
    task t_center;
        wr(8'h24, 32'h100);
        wr(8'h08, 32'h80000009);
        repeat (40) @(posedge pclk);
        win;
        chk(dh, 32'h28);
        chk(da, 32'h2);
        wr(8'h10, 32'h4);
        repeat (40) @(posedge pclk);
        win;
        chk(dh, 32'h40);
        wr(8'h24, 32'h10001);
        wr(8'h28, 32'h1);
        repeat (40) @(posedge pclk);
        chk(group_a_irq, 1'h1);
        wr(8'h24, 32'h0);
        repeat (2) @(posedge pclk);
        chk(group_a_irq, 1'h0);
        $display("center done");
    endtask
    task t_capture;
        wr(8'h44, 32'h100);
        wr(8'h2C, 32'h3);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h9);
        wr(8'h0C, 32'h7);
        repeat (20) @(posedge pclk);
        cap_lvl <= 2'h1;
        repeat (3) @(posedge pclk);
        cap_lvl <= 2'h0;
        repeat (10) @(posedge pclk);
        rc(8'h2C, 32'h13);
        chk(group_a_irq, 1'h1);
        rc(8'h34, 32'h5);
        $display("capture done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_oneshot;
        t_reload;
        t_center;
        t_capture;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
